// [pkg/chm_consts.svh]
// constants for the card host pin mode mux
`ifndef CHM_CONSTS_SVH
`define CHM_CONSTS_SVH

// ------------------------------------------------------------
// address decode
// ------------------------------------------------------------
`define CHM_TF_ADDR_W 3
`define CHM_ADDR_W 11
`define CHM_CIS_BASE 11'h000
`define CHM_CCR_BASE 11'h200
`define CHM_CCR_SEL_BIT 9
`define CHM_MEM_PORT_BASE 11'h000
`define CHM_MEM_PORT_TOP 11'h00F

// ------------------------------------------------------------
// card configuration and status bits
// ------------------------------------------------------------
`define CHM_CCSR_SIGCHG_BIT 3
`define CHM_CCSR_CHANGED_BIT 7
`define CHM_CCSR_AUDIO_BIT 3

// ------------------------------------------------------------
// reset values and data lanes
// ------------------------------------------------------------
`define CHM_CCSR_RESET 8'h00
`define CHM_DATA_W 16
`define CHM_BYTE_W 8

`endif

// [pkg/chm_pkg.sv]
// types for the card host pin mode mux
package chm_pkg;

  typedef enum logic [1:0] {
    CHM_MODE_MEM,
    CHM_MODE_IO,
    CHM_MODE_IDE
  } chm_mode_e;

  typedef enum logic [2:0] {
    CHM_SPACE_NONE,
    CHM_SPACE_IO_PORT,
    CHM_SPACE_MEM_PORT,
    CHM_SPACE_CIS,
    CHM_SPACE_CCR,
    CHM_SPACE_TASKFILE
  } chm_space_e;

  typedef enum logic [1:0] {
    CHM_WAIT_WAIT,
    CHM_WAIT_IORDY,
    CHM_WAIT_DDMARDY,
    CHM_WAIT_DSTROBE
  } chm_wait_fn_e;

  // decoded host access
  typedef struct packed {
    chm_space_e space;
    logic [10:0] offset;
    logic wide;
    logic sel;
  } chm_access_s;

  // status-change sources
  typedef struct packed {
    logic ready;
    logic wprot;
  } chm_status_s;

endpackage : chm_pkg

// [src/chm_addr_decode.sv]
// address decode for the three pin modes
`timescale 1ns/1ps
`default_nettype none
`include "chm_consts.svh"

module chm_addr_decode (
  // mode
  input wire chm_pkg::chm_mode_e mode,
  // host access
  input wire logic [`CHM_ADDR_W-1:0] addr,
  input wire logic reg_sel_n,
  input wire logic io_cycle,
  input wire logic mem_cycle,
  input wire logic wide_cycle,
  // decoded
  output chm_pkg::chm_access_s acc
);

  always_comb begin
    acc = '0;
    acc.space = chm_pkg::CHM_SPACE_NONE;
    acc.wide = wide_cycle;
    acc.sel = io_cycle | mem_cycle;
    if (mode == chm_pkg::CHM_MODE_IDE) begin
      // high lines are grounded by the host, so dropping them costs nothing
      acc.offset = {{(`CHM_ADDR_W-`CHM_TF_ADDR_W){1'b0}}, addr[`CHM_TF_ADDR_W-1:0]};
      if (io_cycle) begin
        acc.space = chm_pkg::CHM_SPACE_TASKFILE;
      end
    end else begin
      acc.offset = addr;
      if (io_cycle) begin
        acc.space = chm_pkg::CHM_SPACE_IO_PORT;
      end else if (mem_cycle && !reg_sel_n) begin
        acc.space = addr[`CHM_CCR_SEL_BIT] ? chm_pkg::CHM_SPACE_CCR : chm_pkg::CHM_SPACE_CIS;
      end else if (mem_cycle) begin
        acc.space = chm_pkg::CHM_SPACE_MEM_PORT;
      end
    end
  end

endmodule : chm_addr_decode
`default_nettype wire

// [src/chm_pin_mux.sv]
// mode-dependent pin functions of the card host port
// ------------------------------------------------------------
// Behaviour
// - IDE decodes only A[2:0] task file
// - PC Card modes decode address with register select
// - memory mode drives first battery detect high
// - memory mode drives second battery detect high
// - I/O mode pulls status-change low on change
// - status-change gated by configuration status register
// - audio output negated when unsupported
// - cable select ignored in PC Card modes
// - IDE wait pin is IORDY outside bursts
// - upper data byte only for 16-bit
// - IDE task file on low byte only
// - DMA request handshakes with acknowledge
// ------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "chm_consts.svh"

module chm_pin_mux #(
  parameter bit AUDIO_SUPPORTED = 1'b0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // mode straps and host pins
  input wire chm_pkg::chm_mode_e mode,
  input wire logic [`CHM_ADDR_W-1:0] addr_pin,
  input wire logic reg_sel_n_pin,
  input wire logic cable_sel_n_pin,
  input wire logic dma_ack_n_pin,
  input wire logic io_cycle_pin,
  input wire logic mem_cycle_pin,
  input wire logic wide_cycle_pin,
  // card core state
  input wire chm_pkg::chm_status_s status,
  input wire logic [7:0] ccsr,
  input wire logic core_busy,
  input wire logic udma_active,
  input wire logic udma_host_write,
  input wire logic udma_ready,
  input wire logic udma_strobe,
  input wire logic dma_pending,
  input wire logic dev_selected,
  input wire logic audio_in,
  input wire logic [`CHM_DATA_W-1:0] core_rdata,
  // pins out
  output logic bvd1_oe,
  output logic bvd1_out,
  output logic bvd2_oe,
  output logic bvd2_out,
  output logic wait_out,
  output logic dmarq_out,
  output logic dmarq_oe,
  output logic [`CHM_DATA_W-1:0] data_out,
  output logic [1:0] data_lane_oe,
  // to core
  output chm_pkg::chm_access_s acc_reg,
  output logic cable_sel_reg,
  output chm_pkg::chm_wait_fn_e wait_fn_reg
);

  // ------------------------------------------------------------
  // pin synchronisers: three stages, change counts when 2 and 3 agree
  // ------------------------------------------------------------
  localparam int SYNC_W = `CHM_ADDR_W + 5;
  logic [SYNC_W-1:0] s1_reg, s2_reg, s3_reg, stab_reg;
  logic [SYNC_W-1:0] s1_next, s2_next, s3_next, stab_next;
  logic [SYNC_W-1:0] raw_pins;

  assign raw_pins = {addr_pin, reg_sel_n_pin, cable_sel_n_pin, dma_ack_n_pin, io_cycle_pin, mem_cycle_pin};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_comb begin
        s1_next[gi] = raw_pins[gi];
        s2_next[gi] = s1_reg[gi];
        s3_next[gi] = s2_reg[gi];
        stab_next[gi] = (s2_reg[gi] == s3_reg[gi]) ? s3_reg[gi] : stab_reg[gi];
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      stab_reg <= '0;
    end else begin
      s1_reg <= s1_next;
      s2_reg <= s2_next;
      s3_reg <= s3_next;
      stab_reg <= stab_next;
    end
  end

  logic [`CHM_ADDR_W-1:0] addr_s;
  logic reg_sel_n_s, cable_sel_n_s, dma_ack_n_s, io_cycle_s, mem_cycle_s;
  assign {addr_s, reg_sel_n_s, cable_sel_n_s, dma_ack_n_s, io_cycle_s, mem_cycle_s} = stab_reg;

  // ------------------------------------------------------------
  // address decode
  // ------------------------------------------------------------
  chm_pkg::chm_access_s acc;
  chm_addr_decode u_dec (
    .mode(mode),
    .addr(addr_s),
    .reg_sel_n(reg_sel_n_s),
    .io_cycle(io_cycle_s),
    .mem_cycle(mem_cycle_s),
    .wide_cycle(wide_cycle_pin),
    .acc(acc)
  );

  // ------------------------------------------------------------
  // status change alert
  // ------------------------------------------------------------
  chm_pkg::chm_status_s status_prev_reg, status_prev_next;
  logic changed_reg, changed_next;
  logic bvd1_reg, bvd1_next, bvd2_reg, bvd2_next, bvd1_oe_reg, bvd1_oe_next, bvd2_oe_reg, bvd2_oe_next;

  always_comb begin
    status_prev_next = status;
    // set wins over the clear in the same cycle
    changed_next = (status != status_prev_reg) ? 1'b1 : (changed_reg & ccsr[`CHM_CCSR_CHANGED_BIT]);
    bvd1_next = 1'b1;
    bvd2_next = 1'b1;
    bvd1_oe_next = 1'b0;
    bvd2_oe_next = 1'b0;
    case (mode)
      chm_pkg::CHM_MODE_MEM: begin
        bvd1_next = 1'b1;
        bvd2_next = 1'b1;
        bvd1_oe_next = 1'b1;
        bvd2_oe_next = 1'b1;
      end
      chm_pkg::CHM_MODE_IO: begin
        bvd1_next = ~(changed_reg & ccsr[`CHM_CCSR_SIGCHG_BIT]);
        bvd1_oe_next = 1'b1;
        // unsupported audio stays negated (high)
        bvd2_next = AUDIO_SUPPORTED ? ~audio_in : 1'b1;
        bvd2_oe_next = 1'b1;
      end
      default: begin
        bvd1_next = 1'b1;
        bvd2_next = 1'b1;
      end
    endcase
  end

  // ------------------------------------------------------------
  // wait pin function and dma request
  // ------------------------------------------------------------
  chm_pkg::chm_wait_fn_e wait_fn_next;
  logic wait_next, dmarq_next, dmarq_oe_next, cable_sel_next;
  logic dmarq_reg, dmarq_oe_reg, wait_reg;

  always_comb begin
    wait_fn_next = chm_pkg::CHM_WAIT_WAIT;
    wait_next = ~core_busy;
    cable_sel_next = 1'b0;
    if (mode == chm_pkg::CHM_MODE_IDE) begin
      cable_sel_next = ~cable_sel_n_s;
      if (udma_active) begin
        wait_fn_next = udma_host_write ? chm_pkg::CHM_WAIT_DDMARDY : chm_pkg::CHM_WAIT_DSTROBE;
        wait_next = udma_host_write ? ~udma_ready : udma_strobe;
      end else begin
        wait_fn_next = chm_pkg::CHM_WAIT_IORDY;
        wait_next = ~core_busy;
      end
    end
    // cable select stays low in PC Card modes: pin not trusted there
    if (mode != chm_pkg::CHM_MODE_IDE) begin
      cable_sel_next = 1'b0;
    end
    // hold request until acknowledge, then drop; re-raise only with more data
    dmarq_next = dmarq_reg;
    if (!dmarq_reg && dma_pending && dma_ack_n_s) begin
      dmarq_next = 1'b1;
    end else if (dmarq_reg && !dma_ack_n_s) begin
      dmarq_next = 1'b0;
    end
    if (mode != chm_pkg::CHM_MODE_IDE || !dev_selected) begin
      dmarq_next = 1'b0;
    end
    dmarq_oe_next = (mode == chm_pkg::CHM_MODE_IDE) && dev_selected;
  end

  // ------------------------------------------------------------
  // data lanes
  // ------------------------------------------------------------
  logic [`CHM_DATA_W-1:0] data_next, data_reg;
  logic [1:0] lane_next, lane_reg;

  always_comb begin
    data_next = core_rdata;
    lane_next = 2'h0;
    if (acc.sel) begin
      lane_next = 2'h1;
      if (acc.space == chm_pkg::CHM_SPACE_TASKFILE) begin
        data_next = {{`CHM_BYTE_W{1'b0}}, core_rdata[`CHM_BYTE_W-1:0]};
      end else if (acc.wide) begin
        lane_next = 2'h3;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      status_prev_reg <= '0;
      changed_reg <= 1'b0;
      bvd1_reg <= 1'b1;
      bvd2_reg <= 1'b1;
      bvd1_oe_reg <= 1'b0;
      bvd2_oe_reg <= 1'b0;
      wait_fn_reg <= chm_pkg::CHM_WAIT_WAIT;
      wait_reg <= 1'b1;
      dmarq_reg <= 1'b0;
      dmarq_oe_reg <= 1'b0;
      cable_sel_reg <= 1'b0;
      data_reg <= '0;
      lane_reg <= 2'h0;
      acc_reg <= '0;
    end else begin
      status_prev_reg <= status_prev_next;
      changed_reg <= changed_next;
      bvd1_reg <= bvd1_next;
      bvd2_reg <= bvd2_next;
      bvd1_oe_reg <= bvd1_oe_next;
      bvd2_oe_reg <= bvd2_oe_next;
      wait_fn_reg <= wait_fn_next;
      wait_reg <= wait_next;
      dmarq_reg <= dmarq_next;
      dmarq_oe_reg <= dmarq_oe_next;
      cable_sel_reg <= cable_sel_next;
      data_reg <= data_next;
      lane_reg <= lane_next;
      acc_reg <= acc;
    end
  end

  assign bvd1_out = bvd1_reg;
  assign bvd2_out = bvd2_reg;
  assign bvd1_oe = bvd1_oe_reg;
  assign bvd2_oe = bvd2_oe_reg;
  assign wait_out = wait_reg;
  assign dmarq_out = dmarq_reg;
  assign dmarq_oe = dmarq_oe_reg;
  assign data_out = data_reg;
  assign data_lane_oe = lane_reg;

endmodule : chm_pin_mux
`default_nettype wire

// [tb/chm_pin_mux_props.sv]
// concurrent checks on the pin mode mux ports
`timescale 1ns/1ps
`default_nettype none
module chm_pin_mux_props #(
  parameter bit AUDIO_SUPPORTED = 1'b0
) (
  // watched ports
  input wire logic clk_sys,
  input wire logic rst,
  input wire chm_pkg::chm_mode_e mode,
  input wire logic dma_ack_n_pin,
  input wire logic [7:0] ccsr,
  input wire logic udma_active,
  input wire logic udma_host_write,
  input wire logic dev_selected,
  input wire logic bvd1_out,
  input wire logic bvd2_out,
  input wire logic dmarq_out,
  input wire logic dmarq_oe,
  input wire logic [1:0] data_lane_oe,
  input wire chm_pkg::chm_access_s acc_reg,
  input wire logic cable_sel_reg,
  input wire chm_pkg::chm_wait_fn_e wait_fn_reg
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  // ----
  // windows of six cycles cover the input synchronisers
  // ----
  sequence mem_s; (mode == chm_pkg::CHM_MODE_MEM) [*6]; endsequence
  sequence io_s; (mode == chm_pkg::CHM_MODE_IO) [*6]; endsequence
  sequence pc_s; (mode != chm_pkg::CHM_MODE_IDE) [*6]; endsequence
  sequence burst_s(w);
    (mode == chm_pkg::CHM_MODE_IDE && udma_active && udma_host_write == w) [*6];
  endsequence
  mem_bvd_high_a: assert property (mem_s |-> bvd1_out && bvd2_out)
    else $error("battery detect low in memory mode");
  alert_gated_a: assert property ((io_s and (!ccsr[3]) [*6]) |-> bvd1_out)
    else $error("status alert while disabled");
  audio_negated_a: assert property (io_s |-> AUDIO_SUPPORTED || bvd2_out)
    else $error("audio line asserted");
  csel_ignored_a: assert property (pc_s |-> !cable_sel_reg)
    else $error("cable select seen in card mode");
  tf_offset_a: assert property (acc_reg.space == chm_pkg::CHM_SPACE_TASKFILE |-> acc_reg.offset[10:3] == 8'h00)
    else $error("task file offset uses high lines");
  iordy_fn_a: assert property ((mode == chm_pkg::CHM_MODE_IDE && !udma_active) [*6] |-> wait_fn_reg == chm_pkg::CHM_WAIT_IORDY)
    else $error("wait pin not ready outside burst");
  burst_write_a: assert property (burst_s(1'b1) |-> wait_fn_reg == chm_pkg::CHM_WAIT_DDMARDY)
    else $error("wait pin wrong in write burst");
  burst_read_a: assert property (burst_s(1'b0) |-> wait_fn_reg == chm_pkg::CHM_WAIT_DSTROBE)
    else $error("wait pin wrong in read burst");
  tf_low_lane_a: assert property ((acc_reg.space == chm_pkg::CHM_SPACE_TASKFILE) [*3] |-> !data_lane_oe[1])
    else $error("upper lane on task file access");
  dmarq_drop_a: assert property ((mode == chm_pkg::CHM_MODE_IDE && !dma_ack_n_pin) [*8] |-> !dmarq_out)
    else $error("request held after acknowledge");
  dmarq_float_a: assert property (!dev_selected [*4] |-> !dmarq_oe)
    else $error("request driven while unselected");
endmodule : chm_pin_mux_props
bind chm_pin_mux chm_pin_mux_props #(.AUDIO_SUPPORTED(AUDIO_SUPPORTED)) u_props (.clk_sys, .rst, .mode,
  .dma_ack_n_pin, .ccsr, .udma_active, .udma_host_write, .dev_selected, .bvd1_out, .bvd2_out,
  .dmarq_out, .dmarq_oe, .data_lane_oe, .acc_reg, .cable_sel_reg, .wait_fn_reg);
`default_nettype wire

// [tb/chm_host_model.sv]
// host bus controller model for the card host pins
`timescale 1ns/1ps
`default_nettype none
module chm_host_model (
  // bench control
  input wire logic clk_sys,
  input wire chm_pkg::chm_mode_e mode,
  input wire logic [10:0] addr_req,
  input wire logic rude,
  input wire logic csel_n,
  input wire logic use_dma,
  input wire logic [3:0] ack_delay,
  input wire logic dmarq_out,
  // host pins
  output logic [10:0] addr_pin,
  output logic cable_sel_n_pin,
  output logic dma_ack_n_pin
);
  logic [3:0] wait_cnt;
  wire logic ide = mode == chm_pkg::CHM_MODE_IDE;
  // rude drives high lines anyway, to probe the decoder
  assign addr_pin = (ide && !rude) ? {8'h00, addr_req[2:0]} : addr_req;
  assign cable_sel_n_pin = ide ? csel_n : 1'b0;
  // acknowledge held until the bench ends the transfer
  always @(posedge clk_sys) begin
    if (!use_dma) begin
      wait_cnt <= ack_delay;
      dma_ack_n_pin <= 1'b1;
    end else if (dmarq_out && wait_cnt != 4'h0) begin
      wait_cnt <= wait_cnt - 4'h1;
    end else if (dmarq_out) begin
      dma_ack_n_pin <= 1'b0;
    end
  end
endmodule : chm_host_model
`default_nettype wire

// [tb/tb.sv]
// self-checking bench for the pin mode mux
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_sys = 1'b0, rst = 1'b1, rude = 1'b0, csel_n = 1'b1, use_dma = 1'b0;
  chm_pkg::chm_mode_e mode = chm_pkg::CHM_MODE_MEM;
  logic [10:0] addr_req = 11'h000;
  logic reg_sel_n_pin = 1'b1, io_cycle_pin = 1'b0, mem_cycle_pin = 1'b0, wide_cycle_pin = 1'b0;
  chm_pkg::chm_status_s status = '0;
  logic [7:0] ccsr = 8'h00;
  logic core_busy = 1'b0, udma_active = 1'b0, udma_host_write = 1'b0, udma_ready = 1'b0;
  logic udma_strobe = 1'b0, dma_pending = 1'b0, dev_selected = 1'b0, audio_in = 1'b0;
  logic [15:0] core_rdata = 16'h0000;
  logic [3:0] ack_delay = 4'h0;
  wire logic [10:0] addr_pin;
  wire logic cable_sel_n_pin, dma_ack_n_pin, bvd1_oe, bvd1_out, bvd2_oe, bvd2_out;
  wire logic wait_out, dmarq_out, dmarq_oe, cable_sel_reg;
  wire logic [15:0] data_out;
  wire logic [1:0] data_lane_oe;
  wire chm_pkg::chm_access_s acc_reg;
  wire chm_pkg::chm_wait_fn_e wait_fn_reg;
  int fails = 0, num_checks = 0, cycles = 0, n;
  chm_host_model host (.clk_sys, .mode, .addr_req, .rude, .csel_n, .use_dma, .ack_delay, .dmarq_out,
    .addr_pin, .cable_sel_n_pin, .dma_ack_n_pin);
  chm_pin_mux uut (.clk_sys, .rst, .mode, .addr_pin, .reg_sel_n_pin, .cable_sel_n_pin, .dma_ack_n_pin,
    .io_cycle_pin, .mem_cycle_pin, .wide_cycle_pin, .status, .ccsr, .core_busy, .udma_active,
    .udma_host_write, .udma_ready, .udma_strobe, .dma_pending, .dev_selected, .audio_in, .core_rdata,
    .bvd1_oe, .bvd1_out, .bvd2_oe, .bvd2_out, .wait_out, .dmarq_out, .dmarq_oe, .data_out,
    .data_lane_oe, .acc_reg, .cable_sel_reg, .wait_fn_reg);
  always #10 clk_sys = ~clk_sys;
  // ----
  // helpers
  // ----
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // inputs always move two ns after the edge
  task automatic step(input int k);
    repeat (k) @(posedge clk_sys);
    #2;
  endtask : step
  function automatic logic [2:0] exp_wait(input logic a, w, b, r, s);
    if (!a) return {chm_pkg::CHM_WAIT_IORDY, !b};
    return w ? {chm_pkg::CHM_WAIT_DDMARDY, !r} : {chm_pkg::CHM_WAIT_DSTROBE, s};
  endfunction : exp_wait
  function automatic chm_pkg::chm_space_e exp_space(input logic rs_n, input logic a9);
    if (rs_n) return chm_pkg::CHM_SPACE_MEM_PORT;
    return a9 ? chm_pkg::CHM_SPACE_CCR : chm_pkg::CHM_SPACE_CIS;
  endfunction : exp_space
  task automatic conclude;
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      conclude();
    end
  end
  initial begin
    void'($urandom(32'h026552C7));
    step(6);
    rst = 1'b0;
    reg_sel_n_pin = 1'b0;
    mem_cycle_pin = 1'b1;
    for (int i = 0; i < 8; i++) begin
      addr_req = 11'($urandom);
      {reg_sel_n_pin, wide_cycle_pin} = 2'($urandom);
      core_rdata = 16'($urandom);
      step(8);
      chk({bvd1_out, bvd1_oe, bvd2_out, bvd2_oe}, 4'hF);
      chk(acc_reg.space, exp_space(reg_sel_n_pin, addr_req[9]));
      chk(data_lane_oe, wide_cycle_pin ? 2'h3 : 2'h1);
      chk(data_out, core_rdata);
      chk(cable_sel_reg, 1'b0);
    end
    $display("memory mode test done");
    mode = chm_pkg::CHM_MODE_IO;
    {reg_sel_n_pin, mem_cycle_pin, audio_in, io_cycle_pin} = 4'hB;
    step(8);
    status = 2'b11;
    step(8);
    chk({bvd1_out, bvd1_oe, bvd2_out, bvd2_oe}, 4'hF);
    chk(acc_reg.space, chm_pkg::CHM_SPACE_IO_PORT);
    ccsr = 8'h88;
    step(8);
    status = 2'b01;
    step(8);
    chk(bvd1_out, 1'b0);
    ccsr = 8'h08;
    step(8);
    chk(bvd1_out, 1'b1);
    $display("io mode test done");
    mode = chm_pkg::CHM_MODE_IDE;
    {mem_cycle_pin, io_cycle_pin} = 2'b01;
    for (int i = 0; i < 12; i++) begin
      {rude, csel_n, wide_cycle_pin} = 3'(i);
      addr_req = 11'($urandom);
      core_rdata = 16'($urandom);
      step(8);
      chk(acc_reg.space, chm_pkg::CHM_SPACE_TASKFILE);
      chk(acc_reg.offset, addr_req[2:0]);
      chk({data_lane_oe, data_out[15:8]}, 10'h100);
      chk(data_out[7:0], core_rdata[7:0]);
      chk(cable_sel_reg, !csel_n);
    end
    for (int i = 0; i < 8; i++) begin
      {udma_active, udma_host_write} = 2'(i);
      {core_busy, udma_ready, udma_strobe} = 3'($urandom);
      step(8);
      chk({wait_fn_reg, wait_out}, exp_wait(udma_active, udma_host_write, core_busy, udma_ready,
        udma_strobe));
    end
    $display("ide decode and wait test done");
    for (int d = 0; d < 2; d++) begin
      // host loads its delay only while idle, so give it one edge first
      ack_delay = d ? 4'hC : 4'h0;
      step(1);
      {dev_selected, dma_pending, use_dma} = 3'h7;
      n = 0;
      while (dma_ack_n_pin !== 1'b0 && n < 40) begin
        chk(dmarq_out, n != 0);
        step(1);
        n++;
      end
      chk(16'(n), 16'(ack_delay) + 16'h0002);
      dma_pending = 1'b0;
      chk(dmarq_oe, 1'b1);
      step(10);
      chk(dmarq_out, 1'b0);
      use_dma = 1'b0;
      step(8);
      chk(dmarq_out, 1'b0);
      dev_selected = 1'b0;
      step(8);
      chk(dmarq_oe, 1'b0);
    end
    $display("dma handshake test done");
    conclude();
  end
endmodule : tb
`default_nettype wire
